// file: design/vtr_pkg.sv
package vtr_pkg;
    localparam logic [7:0]  OFS_VECTOR_TABLE  = 8'h00;
    localparam logic [7:0]  OFS_APP_RESET_CTL = 8'h04;
    localparam int          POS_REGION_SEL    = 29;
    localparam int          POS_OFFSET_HI     = 28;
    localparam int          POS_OFFSET_LO     = 7;
    localparam int          POS_KEY_LO        = 16;
    localparam int          POS_BYTE_ORDER    = 15;
    localparam int          POS_SPLIT_HI      = 10;
    localparam int          POS_SPLIT_LO      = 8;
    localparam int          POS_SYS_RESET     = 2;
    localparam int          POS_CLR_ACTIVE    = 1;
    localparam int          POS_CORE_RESET    = 0;
    localparam logic [15:0] WRITE_KEY         = 16'h05FA;
    localparam logic [15:0] KEY_READBACK      = 16'hFA05;
    localparam logic [31:0] RST_VECTOR_TABLE  = 32'h00000000;
    localparam logic [2:0]  RST_SPLIT         = 3'h0;
    localparam logic        RST_BYTE_ORDER    = 1'b0;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// file: design/vtr_split_if.sv
`timescale 1ns/10ps
// priority byte and split setting in, two parts out
interface vtr_split_if;
    logic [7:0] prio;
    logic [2:0] split;
    logic [7:0] preempt;
    logic [7:0] sub;
    modport owner (output prio, output split, input preempt, input sub);
    modport splitter (input prio, input split, output preempt, output sub);
endinterface

// file: design/vtr_prio_split.sv
`timescale 1ns/10ps
module vtr_prio_split
    import vtr_pkg::*;
(
    vtr_split_if.splitter sp
);
    // number of low bits given to subpriority: split plus one
    function automatic logic [8:0] sub_mask(input logic [2:0] split);
        logic [8:0] m;
        m = (9'h001 << (4'(split) + 4'h1)) - 9'h001;
        return m;
    endfunction

    // split the byte into pre-emption and subpriority parts
    always_comb
    begin
        sp.sub     = sp.prio & 8'(sub_mask(sp.split));
        sp.preempt = 8'((9'(sp.prio) >> (4'(sp.split) + 4'h1)));
    end
endmodule

// file: design/vtr_sysctl.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module vtr_sysctl
    import vtr_pkg::*;
#(
    parameter logic [31:0] CODE_BASE = 32'h00000000,
    parameter logic [31:0] SRAM_BASE = 32'h20000000
)
(
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic [7:0]  PRIO_A,
    input  wire logic [7:0]  PRIO_B,
    output logic [31:0]      VECTOR_TABLE_ADDR,
    output logic             TABLE_REGION_SELECT,
    output logic [2:0]       PRIORITY_SPLIT,
    output logic             BYTE_ORDER_FLAG,
    output logic             SYSTEM_RESET_REQUEST,
    output logic             CLEAR_ACTIVE_STATE,
    output logic             CORE_RESET_REQUEST,
    output logic [7:0]       PREEMPT_A,
    output logic [7:0]       SUB_A,
    output logic             B_WINS
);
    localparam int OFF_W = POS_OFFSET_HI - POS_OFFSET_LO + 1;

    logic             aw_held_ff;
    logic [7:0]       aw_addr_ff;
    logic             w_held_ff;
    logic [31:0]      w_data_ff;
    logic [3:0]       w_strb_ff;
    logic             region_ff;
    logic [OFF_W-1:0] offset_ff;
    logic             byte_order_ff;
    logic [2:0]       split_ff;
    logic             sys_reset_ff;
    logic             clr_active_ff;
    logic             core_reset_ff;
    logic             do_write;
    logic             key_ok;
    logic [31:0]      nxt_rdata;
    logic             nxt_rvalid;
    logic             nxt_a_less;
    logic [31:0]      tbl_merged;

    vtr_split_if sp_a ();
    vtr_split_if sp_b ();

    // register index: 0 table location, 1 reset control, 2 unmapped
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        logic [1:0] idx;
        idx = 2'h2;
        if (addr[7:2] == OFS_VECTOR_TABLE[7:2])
            idx = 2'h0;
        else if (addr[7:2] == OFS_APP_RESET_CTL[7:2])
            idx = 2'h1;
        return idx;
    endfunction

    // merge write data into old byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        return r;
    endfunction

    // write happens once both address and data are held
    assign do_write = aw_held_ff && w_held_ff && !S_AXI_BVALID;
    assign key_ok   = (w_strb_ff[3:2] == 2'h3)
                    && (w_data_ff[31:POS_KEY_LO] == WRITE_KEY);

    // table word with the written byte lanes merged in
    assign tbl_merged = merge({2'h0, region_ff, offset_ff, 7'h00}, w_data_ff, w_strb_ff);

    // write address channel
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            aw_held_ff    <= 1'b0;
            aw_addr_ff    <= 8'h00;
            S_AXI_AWREADY <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held_ff && !S_AXI_AWREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= S_AXI_AWADDR;
            end
            else if (do_write)
                aw_held_ff <= 1'b0;
        end
    end

    // write data channel
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            w_held_ff    <= 1'b0;
            w_data_ff    <= 32'h00000000;
            w_strb_ff    <= 4'h0;
            S_AXI_WREADY <= 1'b0;
        end
        else
        begin
            S_AXI_WREADY <= !w_held_ff && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= S_AXI_WDATA;
                w_strb_ff <= S_AXI_WSTRB;
            end
            else if (do_write)
                w_held_ff <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (reg_index(aw_addr_ff) == 2'h2) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end

    // vector table location register, reserved bits never stored
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            region_ff <= RST_VECTOR_TABLE[POS_REGION_SEL];
            offset_ff <= RST_VECTOR_TABLE[POS_OFFSET_HI:POS_OFFSET_LO];
        end
        else if (do_write && reg_index(aw_addr_ff) == 2'h0)
        begin
            region_ff <= tbl_merged[POS_REGION_SEL];
            offset_ff <= tbl_merged[POS_OFFSET_HI:POS_OFFSET_LO];
        end
    end

    // reset control fields, only on a keyed write
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            byte_order_ff <= RST_BYTE_ORDER;
            split_ff      <= RST_SPLIT;
        end
        else if (do_write && reg_index(aw_addr_ff) == 2'h1 && key_ok)
        begin
            if (w_strb_ff[1])
            begin
                byte_order_ff <= w_data_ff[POS_BYTE_ORDER];
                split_ff      <= w_data_ff[POS_SPLIT_HI:POS_SPLIT_LO];
            end
        end
    end

    // request bits: system reset held until warm reset, others one-cycle pulses
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            sys_reset_ff  <= 1'b0;
            clr_active_ff <= 1'b0;
            core_reset_ff <= 1'b0;
        end
        else
        begin
            clr_active_ff <= 1'b0;
            core_reset_ff <= 1'b0;
            if (do_write && reg_index(aw_addr_ff) == 2'h1 && key_ok && w_strb_ff[0])
            begin
                if (w_data_ff[POS_SYS_RESET])
                    sys_reset_ff <= 1'b1;
                clr_active_ff <= w_data_ff[POS_CLR_ACTIVE];
                core_reset_ff <= w_data_ff[POS_CORE_RESET];
            end
        end
    end

    // read data mux
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        case (reg_index(S_AXI_ARADDR))
            2'h0:
            begin
                nxt_rdata[POS_REGION_SEL]                = region_ff;
                nxt_rdata[POS_OFFSET_HI:POS_OFFSET_LO]   = offset_ff;
            end
            2'h1:
            begin
                nxt_rdata[31:POS_KEY_LO]                 = KEY_READBACK;
                nxt_rdata[POS_BYTE_ORDER]                = byte_order_ff;
                nxt_rdata[POS_SPLIT_HI:POS_SPLIT_LO]     = split_ff;
                nxt_rdata[POS_SYS_RESET]                 = sys_reset_ff;
            end
            default: nxt_rdata = 32'h00000000;
        endcase
        nxt_rvalid = S_AXI_ARVALID && S_AXI_ARREADY;
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && !nxt_rvalid;
            if (nxt_rvalid)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= nxt_rdata;
                S_AXI_RRESP  <= (reg_index(S_AXI_ARADDR) == 2'h2) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // priority split units for the two contenders
    assign sp_a.prio  = PRIO_A;
    assign sp_a.split = split_ff;
    assign sp_b.prio  = PRIO_B;
    assign sp_b.split = split_ff;

    vtr_prio_split u_split_a (.sp(sp_a));
    vtr_prio_split u_split_b (.sp(sp_b));

    // lower pre-emption wins, then lower subpriority, tie to A
    assign nxt_a_less = (sp_a.preempt < sp_b.preempt)
                     || (sp_a.preempt == sp_b.preempt && sp_a.sub <= sp_b.sub);

    // registered outputs
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            VECTOR_TABLE_ADDR <= CODE_BASE;
            PREEMPT_A         <= 8'h00;
            SUB_A             <= 8'h00;
            B_WINS            <= 1'b0;
        end
        else
        begin
            VECTOR_TABLE_ADDR <= (region_ff ? SRAM_BASE : CODE_BASE)
                               + {3'h0, offset_ff, 7'h00};
            PREEMPT_A         <= sp_a.preempt;
            SUB_A             <= sp_a.sub;
            B_WINS            <= !nxt_a_less;
        end
    end

    assign TABLE_REGION_SELECT  = region_ff;
    assign PRIORITY_SPLIT       = split_ff;
    assign BYTE_ORDER_FLAG      = byte_order_ff;
    assign SYSTEM_RESET_REQUEST = sys_reset_ff;
    assign CLEAR_ACTIVE_STATE   = clr_active_ff;
    assign CORE_RESET_REQUEST   = core_reset_ff;
endmodule

// file: sim/vtr_sysctl_props.sv
`timescale 1ns/10ps
module vtr_sysctl_props
    import vtr_pkg::*;
#(
    parameter logic [31:0] CODE_BASE = 32'h00000000,
    parameter logic [31:0] SRAM_BASE = 32'h20000000
)
(
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0]  S_AXI_WSTRB,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic [7:0]  PRIO_A,
    input wire logic [31:0] VECTOR_TABLE_ADDR,
    input wire logic        TABLE_REGION_SELECT,
    input wire logic [2:0]  PRIORITY_SPLIT,
    input wire logic        BYTE_ORDER_FLAG,
    input wire logic        SYSTEM_RESET_REQUEST,
    input wire logic        CLEAR_ACTIVE_STATE,
    input wire logic        CORE_RESET_REQUEST,
    input wire logic [7:0]  PREEMPT_A,
    input wire logic [7:0]  SUB_A
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    // write to the reset control word, address and data taken together
    sequence s_wr_ctl;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            && S_AXI_AWADDR[7:2] == 6'h01;
    endsequence
    sequence s_good_key;
        s_wr_ctl ##0 (S_AXI_WDATA[31:16] == WRITE_KEY && S_AXI_WSTRB == 4'hF);
    endsequence
    sequence s_bad_key;
        s_wr_ctl ##0 (S_AXI_WDATA[31:16] != WRITE_KEY);
    endsequence
    // nothing moves for three cycles
    sequence s_quiet;
        ($stable(PRIORITY_SPLIT) && $stable(BYTE_ORDER_FLAG) && !CLEAR_ACTIVE_STATE
            && !CORE_RESET_REQUEST && !$rose(SYSTEM_RESET_REQUEST))[*3];
    endsequence

    chk_bad_key_quiet: assert property (s_bad_key |=> s_quiet)
        else $error("wrong key write changed state");
    chk_clear_pulse: assert property (s_good_key ##0 S_AXI_WDATA[1] |-> ##[1:3] CLEAR_ACTIVE_STATE)
        else $error("clear active pulse missing");
    chk_core_pulse: assert property (s_good_key ##0 S_AXI_WDATA[0] |-> ##[1:3] CORE_RESET_REQUEST)
        else $error("core reset pulse missing");
    chk_sysreq_set: assert property (s_good_key ##0 S_AXI_WDATA[2] |-> ##[1:3] SYSTEM_RESET_REQUEST)
        else $error("system reset request not raised");
    chk_sysreq_hold: assert property (SYSTEM_RESET_REQUEST |=> SYSTEM_RESET_REQUEST)
        else $error("system reset request dropped before reset");
    chk_pulse_once: assert property (CLEAR_ACTIVE_STATE || CORE_RESET_REQUEST
        |=> !CLEAR_ACTIVE_STATE && !CORE_RESET_REQUEST)
        else $error("request bit did not clear itself");
    chk_key_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] == 6'h01
        |=> S_AXI_RVALID && S_AXI_RDATA[31:16] == KEY_READBACK && S_AXI_RDATA[14:11] == 4'h0)
        else $error("key readback or reserved bits wrong");
    chk_tbl_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] == 6'h00
        |=> S_AXI_RVALID && S_AXI_RDATA[31:30] == 2'h0 && S_AXI_RDATA[6:0] == 7'h00
            && S_AXI_RDATA[29] == TABLE_REGION_SELECT)
        else $error("table register read wrong");
    chk_unmapped_rd: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:3] != 5'h00
        |=> S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
    chk_table_addr: assert property (((VECTOR_TABLE_ADDR
        - ($past(TABLE_REGION_SELECT) ? SRAM_BASE : CODE_BASE)) & 32'hE000007F) == 32'h0)
        else $error("table address not built on chosen region");
    chk_split_math: assert property ($past(RST_N) |->
        PREEMPT_A == ($past(PRIO_A) >> ($past(PRIORITY_SPLIT) + 4'h1))
        && SUB_A == ($past(PRIO_A) & ~(8'hFF << ($past(PRIORITY_SPLIT) + 4'h1))))
        else $error("priority split wrong");
endmodule

bind vtr_sysctl vtr_sysctl_props #(.CODE_BASE(CODE_BASE), .SRAM_BASE(SRAM_BASE)) vtr_sysctl_props_i (
    .REF_CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .PRIO_A,
    .VECTOR_TABLE_ADDR, .TABLE_REGION_SELECT, .PRIORITY_SPLIT, .BYTE_ORDER_FLAG,
    .SYSTEM_RESET_REQUEST, .CLEAR_ACTIVE_STATE, .CORE_RESET_REQUEST, .PREEMPT_A, .SUB_A
);

// file: sim/tb_vtr_sysctl.sv
`timescale 1ns/10ps
module tb_vtr_sysctl;
    logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, trs, bo, sysreq, clr, core, bwins;
    logic [1:0]  bresp, rresp;
    logic [2:0]  split;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr, pa, pb, prea, suba;
    logic [31:0] wdata, rdata, vta;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          num_errors, check_count, n_clr, n_core;

    vtr_sysctl vtr_sysctl_i (
        .REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PRIO_A(pa),
        .PRIO_B(pb), .VECTOR_TABLE_ADDR(vta), .TABLE_REGION_SELECT(trs),
        .PRIORITY_SPLIT(split), .BYTE_ORDER_FLAG(bo), .SYSTEM_RESET_REQUEST(sysreq),
        .CLEAR_ACTIVE_STATE(clr), .CORE_RESET_REQUEST(core), .PREEMPT_A(prea),
        .SUB_A(suba), .B_WINS(bwins)
    );

    // clock at 40 MHz
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // response watcher: oldest note against each answer, pulse counters
    always @(posedge clk)
    begin
        if (rvalid && rready)
            cmp("read data", rq.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            cmp("write resp", 34'(bq.pop_front()), 34'(bresp));
        if (clr)
            n_clr++;
        if (core)
            n_core++;
    end

    // write: both channels offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        @(posedge clk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            arvalid <= arvalid & ~arready;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
    endtask

    function automatic logic [15:0] split8(input logic [7:0] p, input logic [2:0] s);
        return {p >> (s + 4'h1), p & ~(8'hFF << (s + 4'h1))};
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog over the whole run
    initial
    begin
        #300000;
        num_errors++;
        stop_test();
    end

    // main sequence
    initial
    begin
        logic [31:0] d, b;
        logic [15:0] ea, eb;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb, pa, pb} = '0;
        void'($urandom(86));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 34'h0);
        rd(8'h04, 34'hFA050000);
        $display("test reset values done");
        for (int i = 0; i < 5; i++)
        begin
            d = (i == 4) ? 32'hFFFFFFFF : $urandom;
            if (i == 3)
                d[7] = 1'b0;
            wr(8'h00, d, 4'hF, 2'h0);
            rd(8'h00, 34'(d & 32'h3FFFFF80));
            @(negedge clk);
            cmp("table addr", 34'((d[29] ? 32'h20000000 : 32'h0) + (d & 32'h1FFFFF80)), 34'(vta));
            cmp("region", 34'(d[29]), 34'(trs));
        end
        $display("test table location done");
        for (int s = 0; s < 8; s++)
        begin
            b = $urandom;
            wr(8'h04, {16'h05FA, b[0], 4'hF, s[2:0], 8'hF8}, 4'hF, 2'h0);
            rd(8'h04, {18'h0FA05, b[0], 4'h0, s[2:0], 8'h0});
            pa <= 8'($urandom);
            pb <= 8'($urandom);
            repeat (2) @(negedge clk);
            ea = split8(pa, s[2:0]);
            eb = split8(pb, s[2:0]);
            cmp("split a", 34'(ea), 34'({prea, suba}));
            cmp("b wins", 34'(eb[15:8] < ea[15:8] || (eb == ea ? 1'b0 : eb[15:8] == ea[15:8] && eb[7:0] < ea[7:0])), 34'(bwins));
            cmp("fields", 34'({b[0], s[2:0]}), 34'({bo, split}));
        end
        $display("test priority split done");
        wr(8'h04, 32'h12340307, 4'hF, 2'h0);
        wr(8'h04, 32'h05FA0307, 4'h3, 2'h0);
        rd(8'h04, {18'h0FA05, b[0], 7'h07, 8'h0});
        cmp("requests", 34'h0, {n_clr[15:0], n_core[15:0], sysreq, 1'b0});
        wr(8'h04, 32'h05FA0003, 4'hF, 2'h0);
        rd(8'h04, 34'hFA050000);
        cmp("pulses", {16'h0001, 16'h0001, 2'h0}, {n_clr[15:0], n_core[15:0], 2'h0});
        $display("test key and pulses done");
        wr(8'h04, 32'h05FA0004, 4'hF, 2'h0);
        rd(8'h04, 34'hFA050004);
        cmp("sys request", 34'h1, 34'(sysreq));
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp("after reset", 34'h0, {1'b0, sysreq, vta});
        wr(8'h08, 32'hFFFFFFFF, 4'hF, 2'h2);
        rd(8'h0C, {2'h2, 32'h0});
        rd(8'h00, 34'h0);
        $display("test reset request and unmapped done");
        stop_test();
    end
endmodule
